// *** pkg/emp_pkg.sv ***
package emp_pkg;
   // -----------------------------------------------------------
   // geometry
   // -----------------------------------------------------------
   localparam int EMP_BOARDS   = 3;
   localparam int EMP_WINDOWS  = 4;
   localparam int EMP_PAGE_W   = 7;
   localparam int EMP_OFS_W    = 14;
   localparam int EMP_DRAM_W   = 21;
   localparam int EMP_BLK_W    = 6;
   // -----------------------------------------------------------
   // port map, shown for strap code 1
   // -----------------------------------------------------------
   localparam logic [15:0] EMP_WIN0_PAGE_MAP_OFS = 16'h0208;
   localparam logic [15:0] EMP_BASE_BIT0_OFS     = 16'h0209;
   localparam logic [15:0] EMP_WIN1_PAGE_MAP_OFS = 16'h4208;
   localparam logic [15:0] EMP_BASE_BIT1_OFS     = 16'h4209;
   localparam logic [15:0] EMP_WIN2_PAGE_MAP_OFS = 16'h8208;
   localparam logic [15:0] EMP_BASE_BIT2_OFS     = 16'h8209;
   localparam logic [15:0] EMP_WIN3_PAGE_MAP_OFS = 16'hC208;
   localparam logic [15:0] EMP_PARITY_TEST_OFS   = 16'hC209;
   localparam logic [5:0]  EMP_PORT_MID  = 6'h02;
   localparam logic [7:0]  EMP_PORT_LOW [0:7] = '{8'h00, 8'h08, 8'h18,
      8'h58, 8'h68, 8'hA8, 8'hB8, 8'hE8};
   localparam logic [2:0]  EMP_STRAP_OFF = 3'h0;
   // -----------------------------------------------------------
   // fields and reset values
   // -----------------------------------------------------------
   localparam int          EMP_ENABLE_BIT  = 7;
   localparam int          EMP_CTRL_BIT    = 7;
   localparam int          EMP_TEST_WIN    = 3;
   localparam logic [7:0]  EMP_REG_RST     = 8'h00;
   localparam logic [5:0]  EMP_START_BLK   = 6'h31;
   localparam logic [5:0]  EMP_WIN_SPAN    = 6'h04;
   localparam logic [7:0]  EMP_RD_IDLE     = 8'h00;
   // -----------------------------------------------------------
   // carriers
   // -----------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } emp_io_req_t;
   typedef struct packed {
      logic [19:0] addr;
      logic        rd;
      logic        wr;
   } emp_mem_req_t;
   typedef struct packed {
      logic                  rd;
      logic                  wr;
      logic [1:0]            board;
      logic [EMP_DRAM_W-1:0] addr;
   } emp_dram_req_t;
   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   // port hit for a board's strap code, any of the eight ports
   function automatic logic emp_port_hit(input logic [2:0] strap,
                                         input logic [15:0] addr);
      emp_port_hit = (strap != EMP_STRAP_OFF)
         && (addr[13:8] == EMP_PORT_MID)
         && (addr[7:1] == EMP_PORT_LOW[strap][7:1]);
   endfunction
   // partial decode: 16 pages per half, page bits 5:4 ignored
   function automatic logic [EMP_PAGE_W-1:0] emp_phys_page(
      input logic [EMP_PAGE_W-1:0] page);
      emp_phys_page = {2'b00, page[6], page[3:0]};
   endfunction
endpackage

// *** design/emp_board_regs.sv ***
`timescale 1ns/100ps
module emp_board_regs
(
   // clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          reset_n,
   // strap and requests
   input  wire logic [2:0]                    port_strap,
   input  wire emp_pkg::emp_io_req_t          io_req,
   input  wire emp_pkg::emp_mem_req_t         mem_req,
   // decode results
   output logic                               io_hit,
   output logic [7:0]                         io_rdata,
   output logic                               mem_hit,
   output logic [emp_pkg::EMP_DRAM_W-1:0]     mem_dram_addr,
   output logic                               parity_test
);
   import emp_pkg::*;

   logic [7:0]           page_map_reg  [EMP_WINDOWS];
   logic [7:0]           page_map_next [EMP_WINDOWS];
   logic [7:0]           ctrl_reg      [EMP_WINDOWS];
   logic [7:0]           ctrl_next     [EMP_WINDOWS];
   logic [1:0]           io_idx;
   logic [1:0]           win;
   logic [EMP_BLK_W-1:0] start_blk;
   logic [EMP_BLK_W-1:0] blk_rel;
   logic [7:0]           sel_map;

   // -----------------------------------------------------------
   // port decode and readback
   // -----------------------------------------------------------
   assign io_idx   = io_req.addr[15:14];
   assign io_hit   = emp_port_hit(port_strap, io_req.addr);
   assign io_rdata = io_req.addr[0] ? ctrl_reg[io_idx]
                                    : page_map_reg[io_idx];

   // register writes; software may only touch its own board
   always_comb
   begin
      page_map_next = page_map_reg;
      ctrl_next     = ctrl_reg;
      if (io_hit && io_req.wr)
      begin
         if (io_req.addr[0])
            ctrl_next[io_idx] = io_req.wdata;
         else
            page_map_next[io_idx] = io_req.wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         page_map_reg <= '{default: EMP_REG_RST};
         ctrl_reg     <= '{default: EMP_REG_RST};
      end
      else
      begin
         page_map_reg <= page_map_next;
         ctrl_reg     <= ctrl_next;
      end
   end

   // -----------------------------------------------------------
   // window lookup
   // -----------------------------------------------------------
   // the start code sits in bit 7 of three control ports
   assign start_blk = EMP_START_BLK + {3'b000, ctrl_reg[2][EMP_CTRL_BIT],
      ctrl_reg[1][EMP_CTRL_BIT], ctrl_reg[0][EMP_CTRL_BIT]};
   assign blk_rel   = mem_req.addr[19:14] - start_blk;
   assign win       = mem_req.addr[15:14];
   assign sel_map   = page_map_reg[win];
   // a hidden page never answers; boards with enabled overlapping windows all hit
   assign mem_hit = (port_strap != EMP_STRAP_OFF) && (blk_rel < EMP_WIN_SPAN)
      && sel_map[EMP_ENABLE_BIT] && (mem_req.rd || mem_req.wr);
   assign mem_dram_addr = {emp_phys_page(sel_map[EMP_PAGE_W-1:0]),
      mem_req.addr[EMP_OFS_W-1:0]};
   assign parity_test = ctrl_reg[EMP_TEST_WIN][EMP_CTRL_BIT];

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   AST_RESET_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(reset_n) |-> (page_map_reg[0] == 8'h00) && (ctrl_reg[0] == 8'h00))
      else $error("registers not clear after reset");
   AST_PAGE_ENABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      mem_hit |-> page_map_reg[mem_req.addr[15:14]][7])
      else $error("hidden page answered");
   AST_START_RANGE: assert property (@(posedge ref_clk) disable iff (!reset_n)
      mem_hit |-> (mem_req.addr[19:14] >= 6'h31) && (mem_req.addr[19:14] <= 6'h3B))
      else $error("hit outside all start positions");
   AST_ALIAS: assert property (@(posedge ref_clk) disable iff (!reset_n)
      mem_hit |-> (mem_dram_addr[20:19] == 2'b00)
         && (mem_dram_addr[17:14] == page_map_reg[mem_req.addr[15:14]][3:0]))
      else $error("page decode wrong");
endmodule

// *** design/emp_mapper.sv ***
`timescale 1ns/100ps
module emp_mapper
(
   // clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      reset_n,
   // board port straps
   input  wire logic [2:0]                board0_port_strap,
   input  wire logic [2:0]                board1_port_strap,
   input  wire logic [2:0]                board2_port_strap,
   // host i/o and memory cycles
   input  wire emp_pkg::emp_io_req_t      io_req,
   input  wire emp_pkg::emp_mem_req_t     mem_req,
   // register readback
   output logic [7:0]                     io_rdata,
   output logic                           io_rdata_valid,
   // paged memory access
   output emp_pkg::emp_dram_req_t         dram_req,
   output logic                           parity_err
);
   import emp_pkg::*;

   // -----------------------------------------------------------
   // board banks
   // -----------------------------------------------------------
   logic [2:0]            strap     [EMP_BOARDS];
   logic [EMP_BOARDS-1:0] io_hit;
   logic [7:0]            rdata     [EMP_BOARDS];
   logic [EMP_BOARDS-1:0] mem_hit;
   logic [EMP_DRAM_W-1:0] dram_addr [EMP_BOARDS];
   logic [EMP_BOARDS-1:0] test_bit;

   assign strap[0] = board0_port_strap;
   assign strap[1] = board1_port_strap;
   assign strap[2] = board2_port_strap;

   // one bank per board, all sharing the host cycles
   for (genvar b = 0; b < EMP_BOARDS; b++)
   begin : g_board
      emp_board_regs u_regs
      (
         .ref_clk       (ref_clk),
         .reset_n       (reset_n),
         .port_strap    (strap[b]),
         .io_req        (io_req),
         .mem_req       (mem_req),
         .io_hit        (io_hit[b]),
         .io_rdata      (rdata[b]),
         .mem_hit       (mem_hit[b]),
         .mem_dram_addr (dram_addr[b]),
         .parity_test   (test_bit[b])
      );
   end

   // -----------------------------------------------------------
   // readback path
   // -----------------------------------------------------------
   logic [7:0] io_rdata_reg;
   logic [7:0] io_rdata_next;
   logic       io_rdata_valid_reg;
   logic       io_rdata_valid_next;

   // lowest board wins if software straps two boards alike
   always_comb
   begin
      io_rdata_next       = EMP_RD_IDLE;
      io_rdata_valid_next = 1'b0;
      if (io_req.rd)
      begin
         for (int b = EMP_BOARDS - 1; b >= 0; b--)
         begin
            if (io_hit[b])
            begin
               io_rdata_next       = rdata[b];
               io_rdata_valid_next = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         io_rdata_reg       <= EMP_RD_IDLE;
         io_rdata_valid_reg <= 1'b0;
      end
      else
      begin
         io_rdata_reg       <= io_rdata_next;
         io_rdata_valid_reg <= io_rdata_valid_next;
      end
   end

   assign io_rdata       = io_rdata_reg;
   assign io_rdata_valid = io_rdata_valid_reg;

   // -----------------------------------------------------------
   // memory path
   // -----------------------------------------------------------
   emp_dram_req_t dram_req_reg;
   emp_dram_req_t dram_req_next;
   logic          parity_err_reg;
   logic          parity_err_next;

   // overlapping enabled windows are a software fault; the lowest hitting board wins
   always_comb
   begin
      dram_req_next   = '0;
      parity_err_next = 1'b0;
      for (int b = EMP_BOARDS - 1; b >= 0; b--)
      begin
         if (mem_hit[b])
         begin
            dram_req_next.rd    = mem_req.rd;
            dram_req_next.wr    = mem_req.wr && !mem_req.rd;
            dram_req_next.board = 2'(b);
            dram_req_next.addr  = dram_addr[b];
            // the test bit fakes an error on every read while set
            parity_err_next     = mem_req.rd && test_bit[b];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dram_req_reg   <= '0;
         parity_err_reg <= 1'b0;
      end
      else
      begin
         dram_req_reg   <= dram_req_next;
         parity_err_reg <= parity_err_next;
      end
   end

   assign dram_req   = dram_req_reg;
   assign parity_err = parity_err_reg;

   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   logic all_off;
   assign all_off = (board0_port_strap == 3'h0) && (board1_port_strap == 3'h0)
      && (board2_port_strap == 3'h0);

   AST_READ_LATENCY: assert property (io_req.rd && (|io_hit)
      |=> io_rdata_valid && (io_rdata == $past(rdata[0]) || !$past(io_hit[0])))
      else $error("readback late or wrong");
   AST_STRAP_OFF: assert property (all_off |=> !io_rdata_valid && !dram_req.rd
      && !dram_req.wr)
      else $error("disabled board answered");
   // the host leaves one idle cycle between cycles, so the read comes two edges later
   AST_WRITE_BACK: assert property ((io_req.wr && io_hit[0] && !io_hit[1] && !io_hit[2])
      ##1 !io_req.wr ##1 (io_req.rd && io_hit[0] && io_req.addr == $past(io_req.addr, 2))
      |=> io_rdata == $past(io_req.wdata, 3))
      else $error("written value not read back");
   // only the lowest hitting board decides, so look at its test bit
   AST_PARITY: assert property (mem_req.rd && (mem_hit[0] ? test_bit[0]
      : mem_hit[1] ? test_bit[1] : (mem_hit[2] && test_bit[2]))
      |=> parity_err && dram_req.rd)
      else $error("parity test not reported");
   AST_NO_PARITY: assert property (!(|test_bit) |=> !parity_err)
      else $error("spurious parity error");
   AST_OFFSET: assert property (dram_req.rd || dram_req.wr
      |-> dram_req.addr[13:0] == $past(mem_req.addr[13:0]))
      else $error("window offset lost");
   AST_WINDOW_OFF: assert property ($rose(reset_n) |-> ##[0:2] !dram_req.rd)
      else $error("window active after reset");
   AST_START_C4: assert property (mem_hit[0] && (board0_port_strap != 3'h0)
      |-> mem_req.addr[19:14] != 6'h30)
      else $error("hit below lowest start");

   COV_READ: cover property (io_req.rd && io_hit[0] ##1 io_rdata_valid);
   COV_MEM_WR: cover property (mem_req.wr ##1 dram_req.wr);
   COV_PARITY: cover property (parity_err);
   COV_BOARD2: cover property (dram_req.rd && dram_req.board == 2'd2);
endmodule

// *** tb/emp_host_model.sv ***
`timescale 1ns/100ps
module emp_host_model
(
   // clock
   input  wire logic             ref_clk,
   // host cycles toward the mapper
   output emp_pkg::emp_io_req_t  io_req,
   output emp_pkg::emp_mem_req_t mem_req
);
   import emp_pkg::*;
   logic parity_test_allowed = 1'b0;
   // buses idle from time zero
   initial
   begin
      io_req  = '0;
      mem_req = '0;
   end
   // one i/o cycle; the released address is inverted so a stale copy never decodes
   task automatic io_cycle(input logic [15:0] a, input logic wr, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (wr && a[15:14] == 2'b11 && a[0] && !parity_test_allowed)
         v[7] = 1'b0;
      @(posedge ref_clk);
      #1;
      io_req = '{addr: a, rd: !wr, wr: wr, wdata: v};
      @(posedge ref_clk);
      #1;
      io_req = '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~v};
   endtask
   // one memory cycle, same one-edge strobe
   task automatic mem_cycle(input logic [19:0] a, input logic wr);
      @(posedge ref_clk);
      #1;
      mem_req = '{addr: a, rd: !wr, wr: wr};
      @(posedge ref_clk);
      #1;
      mem_req = '{addr: ~a, rd: 1'b0, wr: 1'b0};
   endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   import emp_pkg::*;
   logic          ref_clk;
   logic          reset_n;
   logic [2:0]    st [0:2];
   emp_io_req_t   io_req;
   emp_mem_req_t  mem_req;
   logic [7:0]    io_rdata;
   logic          io_rdata_valid;
   emp_dram_req_t dram_req;
   logic          parity_err;
   logic [7:0]    shadow [0:2][0:7];
   logic [31:0]   notes [$];
   logic [31:0]   seed = 32'h71EA;
   int            error_cnt = 0;
   int            n_checks = 0;
   int            cyc = 0;
   localparam logic [7:0] LOW [0:7] = '{8'h00, 8'h08, 8'h18, 8'h58, 8'h68, 8'hA8, 8'hB8, 8'hE8};

   emp_mapper emp_mapper_inst
   (
      .ref_clk           (ref_clk),
      .reset_n           (reset_n),
      .board0_port_strap (st[0]),
      .board1_port_strap (st[1]),
      .board2_port_strap (st[2]),
      .io_req            (io_req),
      .mem_req           (mem_req),
      .io_rdata          (io_rdata),
      .io_rdata_valid    (io_rdata_valid),
      .dram_req          (dram_req),
      .parity_err        (parity_err)
   );
   emp_host_model emp_host_model_inst
   (
      .ref_clk (ref_clk),
      .io_req  (io_req),
      .mem_req (mem_req)
   );

   // clock at 200 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      rnd = seed[7:0];
   endfunction
   // port of register r: index in 15:14, page map or control in bit 0
   function automatic logic [15:0] pa(input logic [2:0] s, input logic [2:0] r);
      pa = {r[2:1], 6'h02, LOW[s][7:1], r[0]};
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic take(input logic [31:0] got);
      check(got, (notes.size() != 0) ? notes.pop_front() : ~got);
   endtask
   // let the last result reach the monitor before reset wipes it
   task automatic hold_reset();
      @(posedge ref_clk);
      #1;
      reset_n = 1'b0;
      foreach (shadow[i, j]) shadow[i][j] = 8'h00;
      repeat (16) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
   endtask
   task automatic wr_reg(input int b, input logic [2:0] r, input logic [7:0] d);
      if (st[b] != 3'h0)
         shadow[b][r] = d;
      emp_host_model_inst.io_cycle(pa(st[b], r), 1'b1, d);
   endtask
   // a disabled board must stay silent, so no note is queued for it
   task automatic rd_reg(input int b, input logic [2:0] r);
      if (st[b] != 3'h0)
         notes.push_back({24'h0, shadow[b][r]});
      emp_host_model_inst.io_cycle(pa(st[b], r), 1'b0, 8'h00);
   endtask
   // lowest board wins an overlap, so the search runs downward
   task automatic mem(input logic [5:0] blk, input logic wr);
      logic [15:0] off;
      logic [19:0] a;
      logic [5:0]  base;
      logic [7:0]  m;
      logic [31:0] e;
      logic        hit;
      off = {rnd(), rnd()};
      a = {blk, off[13:0]};
      hit = 1'b0;
      for (int b = 2; b >= 0; b--)
      begin
         base = 6'h31 + {shadow[b][5][7], shadow[b][3][7], shadow[b][1][7]};
         m = shadow[b][{a[15:14], 1'b0}];
         if (st[b] != 3'h0 && blk >= base && blk <= base + 6'h03 && m[7])
         begin
            hit = 1'b1;
            e = {4'h1, !wr, wr, !wr & shadow[b][7][7], 2'(b), 2'b00, m[6], m[3:0], a[13:0]};
         end
      end
      if (hit)
         notes.push_back(e);
      emp_host_model_inst.mem_cycle(a, wr);
   endtask

   // ------------------------------------------------------------
   // result monitor: every pulse takes the oldest note
   // ------------------------------------------------------------
   always @(negedge ref_clk)
      if (reset_n === 1'b1)
      begin
         if (io_rdata_valid !== 1'b0)
            take({24'h0, io_rdata});
         if (dram_req.rd !== 1'b0 || dram_req.wr !== 1'b0 || parity_err !== 1'b0)
            take({4'h1, dram_req.rd, dram_req.wr, parity_err, dram_req.board, dram_req.addr});
      end
   // hang guard, far above the expected run length
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      reset_n = 1'b0;
      st = '{3'h1, 3'h0, 3'h0};
      hold_reset();
      for (int r = 0; r < 8; r++)
         rd_reg(0, 3'(r));
      for (int s = 1; s < 8; s++)
      begin
         st[0] = 3'(s);
         for (int r = 0; r < 8; r++)
         begin
            wr_reg(0, 3'(r), rnd() & ((r == 7) ? 8'h7F : 8'hFF));
            rd_reg(0, 3'(r));
         end
      end
      st[0] = 3'h0;
      rd_reg(0, 3'h0);
      st[0] = 3'h1;
      // every start code, blocks one below and one above the region too
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(0, 3'h1, {c[0], 7'h00});
         wr_reg(0, 3'h3, {c[1], 7'h00});
         wr_reg(0, 3'h5, {c[2], 7'h00});
         for (int w = 0; w < 4; w++)
            wr_reg(0, 3'(2 * w), rnd() | 8'h80);
         for (int j = -1; j < 5; j++)
         begin
            mem(6'(49 + c + j), 1'b0);
            mem(6'(49 + c + j), 1'b1);
         end
      end
      for (int w = 0; w < 4; w++)
      begin
         wr_reg(0, 3'(2 * w), rnd() & 8'h7F);
         mem(6'(56 + w), 1'b0);
      end
      // two more boards, overlapping regions
      st[1] = 3'h3;
      st[2] = 3'h7;
      wr_reg(2, 3'h3, 8'h80);
      for (int b = 1; b < 3; b++)
         for (int w = 0; w < 4; w++)
            wr_reg(b, 3'(2 * w), rnd() | 8'h80);
      for (int k = 48; k < 56; k++)
         mem(6'(k), 1'b0);
      // parity test bit fires on reads only
      emp_host_model_inst.parity_test_allowed = 1'b1;
      wr_reg(1, 3'h7, 8'h80);
      mem(6'h34, 1'b0);
      mem(6'h34, 1'b0);
      mem(6'h34, 1'b1);
      wr_reg(1, 3'h7, 8'h00);
      emp_host_model_inst.parity_test_allowed = 1'b0;
      mem(6'h34, 1'b0);
      // second reset while everything is programmed
      hold_reset();
      for (int r = 0; r < 8; r++)
         rd_reg(1, 3'(r));
      mem(6'h31, 1'b0);
      repeat (4) @(posedge ref_clk);
      check(notes.size(), 0);
      wrap_up();
   end
endmodule
